// [common/pmt_link_if.sv]
`timescale 1ns/1ps
interface pmt_link_if;
    import pmt_pkg::*;
    logic txclk_drv;
    logic txclk_oe;
    logic txclk;
    logic ref_clk;
    logic [TXD_W-1:0] txd;
    logic symbol_tx_msb;
    logic txen;
    logic txer;
    logic irq_o;
    logic irq_oe;
    logic irq_out_n;

    // Undriven clock pin reads low; open-drain line idles high on its pull-up
    assign txclk = txclk_oe ? txclk_drv : 1'b0;
    assign irq_out_n = (irq_oe && !irq_o) ? 1'b0 : 1'b1;

    modport phy (
        output txclk_drv,
        output txclk_oe,
        output irq_o,
        output irq_oe,
        input ref_clk,
        input txd,
        input symbol_tx_msb,
        input txen,
        input txer
    );

    modport mac (
        input txclk,
        input ref_clk,
        input irq_out_n,
        output txd,
        output symbol_tx_msb,
        output txen,
        output txer
    );
endinterface

// [common/pmt_pkg.sv]
package pmt_pkg;
    // ------------------------------------------------------------
    // Clock and link rates
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int TXCLK_100_HZ = 25_000_000;
    localparam int TXCLK_10_HZ = 2_500_000;
    localparam int TXCLK_100_DIV = CLK_HZ / (2 * TXCLK_100_HZ);
    localparam int TXCLK_10_DIV = CLK_HZ / (2 * TXCLK_10_HZ);
    // Half periods in clk cycles, never below one cycle
    localparam int TXCLK_100_HALF = (TXCLK_100_DIV < 1) ? 1 : TXCLK_100_DIV;
    localparam int TXCLK_10_HALF = (TXCLK_10_DIV < 1) ? 1 : TXCLK_10_DIV;
    localparam int HALF_W = 8;

    // ------------------------------------------------------------
    // Link widths and input conditioning
    // ------------------------------------------------------------
    localparam int TXD_W = 4;
    localparam int CODE_W = 5;
    localparam int PIN_LAG = 4;
    localparam int REF_LAG = 2;
    localparam logic [2:0] STRAP_WAIT = 3'h4;

    // ------------------------------------------------------------
    // Code groups and reset values
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_TX_ERROR = 5'h04;
    localparam logic [TXD_W-1:0] TXD_IDLE = 4'h0;
    localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;

    // Standard 4B/5B data code groups
    function automatic logic [CODE_W-1:0] pmt_encode_4b5b(input logic [TXD_W-1:0] nib);
        logic [CODE_W-1:0] c;
        c = 5'h1E;
        case (nib)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction
endpackage

// [rtl/pmt_mac_tx.sv]
`timescale 1ns/1ps
module pmt_mac_tx
    import pmt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    pmt_link_if.mac link,
    input wire logic rmii_mode,
    input wire logic eee_enable,
    input wire logic symbol_mode,
    input wire logic [CODE_W-1:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_err,
    input wire logic lpi_req,
    output logic tx_ready,
    output logic irq_seen
);
    // ------------------------------------------------------------
    // Pin conditioning: three flops, a change counts when two agree
    // ------------------------------------------------------------
    logic [2:0] s1_r, s2_r, s3_r, q_r, q_prev_r;
    wire [2:0] pins = {link.irq_out_n, link.ref_clk, link.txclk};
    wire [2:0] agree = ~(s2_r ^ s3_r);
    always_ff @(posedge clk)
    begin
        s1_r <= pins;
        s2_r <= s1_r;
        s3_r <= s2_r;
        q_r <= (s3_r & agree) | (q_r & ~agree);
        q_prev_r <= q_r;
    end

    // Launch on the falling edge the phy side sees, so data is settled at its rising edge
    wire clk_src = rmii_mode ? q_r[1] : q_r[0];
    wire clk_src_prev = rmii_mode ? q_prev_r[1] : q_prev_r[0];
    wire launch = clk_src_prev && !clk_src;
    logic phase_r;
    logic [CODE_W-1:0] hold_r;
    assign tx_ready = launch && (!rmii_mode || !phase_r);
    wire take = tx_ready && tx_valid;
    // Lpi request only outside a frame
    wire lpi_drive = eee_enable && !rmii_mode && lpi_req;
    // Fifth bit only in symbol mode over mii
    wire msb_drive = symbol_mode && !rmii_mode;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            phase_r <= 1'b0;
            hold_r <= CODE_RESET;
            link.txd <= TXD_IDLE;
            link.symbol_tx_msb <= 1'b0;
            link.txen <= 1'b0;
            link.txer <= 1'b0;
            irq_seen <= 1'b0;
        end
        else
        begin
            irq_seen <= !q_r[2];
            if (launch)
            begin
                if (rmii_mode && phase_r)
                begin
                    // Upper lines held low in rmii
                    link.txd <= {2'b00, hold_r[3:2]};
                    link.txen <= 1'b1;
                    link.txer <= 1'b0;
                    phase_r <= 1'b0;
                end
                else if (take)
                begin
                    hold_r <= tx_data;
                    link.txen <= 1'b1;
                    link.txd <= rmii_mode ? {2'b00, tx_data[1:0]} : tx_data[3:0];
                    link.symbol_tx_msb <= msb_drive ? tx_data[4] : 1'b0;
                    link.txer <= tx_err && !rmii_mode;
                    phase_r <= rmii_mode;
                end
                else
                begin
                    link.txen <= 1'b0;
                    link.txd <= TXD_IDLE;
                    link.symbol_tx_msb <= 1'b0;
                    link.txer <= lpi_drive;
                end
            end
        end
    end
endmodule

// [rtl/pmt_phy_tx.sv]
`timescale 1ns/1ps
// How it works
// - Enable marks valid nibbles, dibits in rmii
// - Mac grounds upper data lines in rmii
// - Error at 100M over mii substitutes error code group
// - Error with enable ignored at 10M
// - With eee over mii, error without enable means lpi
// - Symbol mode over mii: extra line is code msb
// - Mii drives tx clock 12.5/2.5 MHz from 25 MHz clk, latches inputs
// - Interrupt is active low open drain
// - Software writes zero to reserved bits
// - Software ignores reserved bits and addresses
// - Works from strap defaults without registers
// - Runs 10 or 100 Mbps by negotiation; here the speed_100 input sets the rate, with no negotiation
// - Strap low mii, high rmii
module pmt_phy_tx
    import pmt_pkg::*;
#(
    parameter int HALF_100 = TXCLK_100_HALF,
    parameter int HALF_10 = TXCLK_10_HALF
)
(
    input wire logic clk,
    input wire logic resetn,
    pmt_link_if.phy link,
    input wire logic interface_select_strap,
    input wire logic speed_100,
    input wire logic eee_enable,
    input wire logic symbol_mode,
    input wire logic irq_request,
    output logic rmii_mode,
    output logic [TXD_W-1:0] tx_nibble,
    output logic [CODE_W-1:0] tx_code,
    output logic tx_valid,
    output logic tx_err_sub,
    output logic tx_active,
    output logic tx_lpi
);
    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    // Bit map: 0 ref clk, 1 enable, 2 error, 3 msb, 4 strap, 8:5 data
    localparam int NP = 9;
    logic [NP-1:0] s1_r, s2_r, s3_r, q_r;
    logic ref_prev_r;
    logic [REF_LAG-1:0] ref_rise_dly_r;
    wire [NP-1:0] pins = {link.txd, interface_select_strap, link.symbol_tx_msb,
        link.txer, link.txen, link.ref_clk};
    wire [NP-1:0] agree = ~(s2_r ^ s3_r);
    wire ref_rise = q_r[0] && !ref_prev_r;
    always_ff @(posedge clk)
    begin
        s1_r <= pins;
        s2_r <= s1_r;
        s3_r <= s2_r;
        q_r <= (s3_r & agree) | (q_r & ~agree);
        ref_prev_r <= q_r[0];
        ref_rise_dly_r <= {ref_rise_dly_r[REF_LAG-2:0], ref_rise};
    end
    wire en_q = q_r[1];
    wire er_q = q_r[2];
    wire msb_q = q_r[3];
    wire [TXD_W-1:0] txd_q = q_r[8:5];

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic [2:0] strap_cnt_r;
    logic strap_done_r;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            strap_cnt_r <= 3'h0;
            strap_done_r <= 1'b0;
            rmii_mode <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            // Wait until the conditioned strap has passed the pipeline
            strap_cnt_r <= strap_cnt_r + 3'h1;
            if (strap_cnt_r == STRAP_WAIT)
            begin
                strap_done_r <= 1'b1;
                rmii_mode <= q_r[4];
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit clock divider
    // ------------------------------------------------------------
    // Limitation: at 25 MHz system clock the 100M clock tops out at half rate
    // Limitation: half period must exceed the mac's five-cycle launch lag
    logic [HALF_W-1:0] div_cnt_r;
    logic txclk_r;
    logic [PIN_LAG-1:0] rise_dly_r;
    wire [HALF_W-1:0] half_m1 = speed_100 ? HALF_W'(HALF_100 - 1) : HALF_W'(HALF_10 - 1);
    wire div_wrap = (div_cnt_r >= half_m1);
    wire mii_run = strap_done_r && !rmii_mode;
    always_ff @(posedge clk)
    begin
        if (!resetn || !mii_run)
        begin
            div_cnt_r <= '0;
            txclk_r <= 1'b0;
            rise_dly_r <= '0;
        end
        else
        begin
            div_cnt_r <= div_wrap ? '0 : div_cnt_r + 1'b1;
            if (div_wrap)
            begin
                txclk_r <= !txclk_r;
            end
            // Sample late by the pin lag so data is seen as it stood at the edge
            rise_dly_r <= {rise_dly_r[PIN_LAG-2:0], div_wrap && !txclk_r};
        end
    end
    assign link.txclk_drv = txclk_r;
    assign link.txclk_oe = mii_run;

    // ------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------
    wire mii_sample = mii_run && rise_dly_r[PIN_LAG-1];
    // Rising edge of reference clock, taken late
    // Mac dibit lands just after the rise, so wait for it to settle
    wire rmii_sample = strap_done_r && rmii_mode && ref_rise_dly_r[REF_LAG-1];

    logic dibit_hi_r;
    logic [1:0] dibit_lo_r;
    // Upper lines only count in mii
    wire [TXD_W-1:0] nib_mii = txd_q;
    wire [TXD_W-1:0] nib_rmii = {txd_q[1:0], dibit_lo_r};
    wire rmii_word = rmii_sample && en_q && dibit_hi_r;
    // Error dropped at 10M and in rmii
    wire err_use = er_q && speed_100 && !rmii_mode;
    wire sub_err = mii_sample && en_q && err_use;
    // Raw five bit group in symbol mode
    wire [CODE_W-1:0] sym_code = {msb_q, txd_q};
    wire [CODE_W-1:0] mii_code = sub_err ? CODE_TX_ERROR :
        (symbol_mode ? sym_code : pmt_encode_4b5b(nib_mii));
    // Lpi when enable low and error high under eee
    wire lpi_now = eee_enable && !en_q && er_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dibit_hi_r <= 1'b0;
            dibit_lo_r <= 2'b00;
            tx_nibble <= TXD_IDLE;
            tx_code <= CODE_RESET;
            tx_valid <= 1'b0;
            tx_err_sub <= 1'b0;
            tx_active <= 1'b0;
            tx_lpi <= 1'b0;
        end
        else
        begin
            tx_valid <= 1'b0;
            tx_err_sub <= 1'b0;
            if (mii_sample)
            begin
                tx_active <= en_q;
                tx_lpi <= lpi_now;
                if (en_q)
                begin
                    tx_nibble <= nib_mii;
                    tx_code <= mii_code;
                    tx_valid <= 1'b1;
                    tx_err_sub <= sub_err;
                end
            end
            else if (rmii_sample)
            begin
                tx_active <= en_q;
                tx_lpi <= 1'b0;
                // Low dibit first; an odd dibit at frame end is dropped
                dibit_hi_r <= en_q && !dibit_hi_r;
                dibit_lo_r <= txd_q[1:0];
                if (rmii_word)
                begin
                    tx_nibble <= nib_rmii;
                    tx_code <= pmt_encode_4b5b(nib_rmii);
                    tx_valid <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    // Pull low only, pull-up gives idle high
    logic irq_r;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= irq_request;
        end
    end
    assign link.irq_o = 1'b0;
    assign link.irq_oe = irq_r;
endmodule

// [tb/pmt_tx_monitor.sv]
`timescale 1ns/1ps
module pmt_tx_monitor
    import pmt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic txclk_drv,
    input wire logic txclk_oe,
    input wire logic [TXD_W-1:0] txd,
    input wire logic symbol_tx_msb,
    input wire logic txen,
    input wire logic txer,
    input wire logic irq_o,
    input wire logic irq_oe,
    input wire logic irq_out_n
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ------------------------------------------------
    // Link checks
    // ------------------------------------------------
    AST_IRQ_DRIVES_LOW: assert property (irq_o == 1'b0)
        else $error("interrupt pin driven high");
    AST_IRQ_LINE: assert property (irq_out_n == !irq_oe)
        else $error("interrupt line level wrong");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn |=> !txen && !txclk_oe)
        else $error("link active after reset");
    AST_TXCLK_HALF: assert property (txclk_oe && $changed(txclk_drv) |=> $stable(txclk_drv)[*4])
        else $error("tx clock half period too short");
    AST_TXCLK_RUNS: assert property (txclk_oe |-> ##[1:8] $changed(txclk_drv))
        else $error("tx clock stopped");
    AST_OE_STEADY: assert property ($rose(txclk_oe) |=> txclk_oe[*8])
        else $error("tx clock drive dropped");
    AST_RMII_UPPER: assert property (txen && !txclk_oe |-> txd[3:2] == 2'b00)
        else $error("upper data lines not grounded");
    AST_RMII_MSB: assert property (txen && !txclk_oe |-> !symbol_tx_msb)
        else $error("symbol msb used without tx clock");
    // Enable may only move while tx clock is low, so the rise latches it
    AST_TXEN_LOW_PHASE: assert property (txclk_oe && $changed(txen) |-> !txclk_drv)
        else $error("enable moved in high phase");
    cover property (txen && txclk_oe);
    cover property (txen && !txclk_oe);
    cover property (irq_oe);
    cover property (txer && !txen);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import pmt_pkg::*;
    localparam logic [CODE_W-1:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b0;
    logic speed_100 = 1'b1;
    logic eee_enable = 1'b0;
    logic symbol_mode = 1'b0;
    logic irq_request = 1'b0;
    logic [CODE_W-1:0] tx_data = 5'h00;
    logic tx_valid = 1'b0;
    logic tx_err = 1'b0;
    logic lpi_req = 1'b0;
    logic rmii_mode;
    logic tx_ready;
    logic irq_seen;
    logic ph_valid;
    logic ph_sub;
    logic ph_active;
    logic ph_lpi;
    logic [TXD_W-1:0] ph_nibble;
    logic [CODE_W-1:0] ph_code;
    int n_mismatch = 0;
    int tests_run = 0;
    int i;
    pmt_link_if link ();

    always #20 clk = ~clk;
    // Reference clock free-running, phase unrelated to clk
    initial
    begin
        link.ref_clk = 1'b0;
        #7;
        forever #160 link.ref_clk = ~link.ref_clk;
    end

    pmt_phy_tx #(.HALF_100(6), .HALF_10(8)) u_pmt_phy_tx (.clk(clk), .resetn(resetn),
        .link(link.phy), .interface_select_strap(strap), .speed_100(speed_100),
        .eee_enable(eee_enable), .symbol_mode(symbol_mode), .irq_request(irq_request),
        .rmii_mode(rmii_mode), .tx_nibble(ph_nibble), .tx_code(ph_code), .tx_valid(ph_valid),
        .tx_err_sub(ph_sub), .tx_active(ph_active), .tx_lpi(ph_lpi));
    pmt_mac_tx u_pmt_mac_tx (.clk(clk), .resetn(resetn), .link(link.mac), .rmii_mode(rmii_mode),
        .eee_enable(eee_enable), .symbol_mode(symbol_mode), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_err(tx_err), .lpi_req(lpi_req), .tx_ready(tx_ready),
        .irq_seen(irq_seen));
    pmt_tx_monitor u_pmt_tx_monitor (.clk(clk), .resetn(resetn), .txclk_drv(link.txclk_drv),
        .txclk_oe(link.txclk_oe), .txd(link.txd), .symbol_tx_msb(link.symbol_tx_msb),
        .txen(link.txen), .txer(link.txer), .irq_o(link.irq_o), .irq_oe(link.irq_oe),
        .irq_out_n(link.irq_out_n));

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic report_and_stop();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic expired();
        n_mismatch++;
        $display("[FAIL] t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    task automatic do_reset(input logic s, input logic spd);
        @(negedge clk);
        resetn = 1'b0;
        strap = s;
        speed_100 = spd;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        // Strap capture plus synchroniser fill
        repeat (12) @(negedge clk);
        check_vec(rmii_mode, s);
        check_vec(link.txclk_oe, !s);
    endtask

    task automatic send(input logic [4:0] d, input logic err, input logic [4:0] exp_code,
        input logic exp_sub);
        logic [3:0] exp_pin;
        exp_pin = rmii_mode ? {2'b00, d[1:0]} : d[3:0];
        @(negedge clk);
        tx_data = d;
        tx_err = err;
        tx_valid = 1'b1;
        for (i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge clk);
        if (i >= 400) expired();
        @(negedge clk);
        tx_valid = 1'b0;
        tx_err = 1'b0;
        @(negedge clk);
        check_vec(link.txen, 1'b1);
        check_vec(link.txd, exp_pin);
        check_vec(link.symbol_tx_msb, symbol_mode && !rmii_mode && d[4]);
        for (i = 0; i < 400 && ph_valid !== 1'b1; i++) @(negedge clk);
        if (i >= 400) expired();
        check_vec(ph_code, exp_code);
        check_vec(ph_nibble, d[3:0]);
        check_vec(ph_sub, exp_sub);
        check_vec(ph_active, 1'b1);
    endtask

    task automatic wait_lpi(input logic v);
        for (i = 0; i < 400 && ph_lpi !== v; i++) @(negedge clk);
        if (i >= 400) expired();
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_mii100();
        for (int k = 0; k < 16; k++)
        begin
            send(5'(k), k[0], k[0] ? CODE_TX_ERROR : ENC[k], k[0]);
        end
    endtask

    task automatic t_symbol();
        symbol_mode = 1'b1;
        send(5'h15, 1'b0, 5'h15, 1'b0);
        send(5'h0A, 1'b1, CODE_TX_ERROR, 1'b1);
        symbol_mode = 1'b0;
    endtask

    task automatic t_eee();
        eee_enable = 1'b1;
        send(5'h07, 1'b1, CODE_TX_ERROR, 1'b1);
        lpi_req = 1'b1;
        wait_lpi(1'b1);
        check_vec({link.txen, link.txer}, 2'b01);
        lpi_req = 1'b0;
        wait_lpi(1'b0);
        eee_enable = 1'b0;
        lpi_req = 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge clk);
            check_vec(ph_lpi, 1'b0);
        end
        lpi_req = 1'b0;
    endtask

    task automatic t_irq();
        irq_request = 1'b1;
        for (i = 0; i < 50 && irq_seen !== 1'b1; i++) @(negedge clk);
        if (i >= 50) expired();
        check_vec(link.irq_out_n, 1'b0);
        irq_request = 1'b0;
        for (i = 0; i < 50 && irq_seen !== 1'b0; i++) @(negedge clk);
        if (i >= 50) expired();
        check_vec(link.irq_out_n, 1'b1);
    endtask

    task automatic t_mii10();
        for (int k = 0; k < 4; k++)
        begin
            send(5'(k * 5), 1'b1, ENC[k * 5], 1'b0);
        end
    endtask

    task automatic t_rmii();
        send(5'h0C, 1'b1, ENC[12], 1'b0);
        send(5'h03, 1'b0, ENC[3], 1'b0);
        check_vec(link.txclk, 1'b0);
    endtask

    initial
    begin
        do_reset(1'b0, 1'b1);
        t_mii100();
        t_symbol();
        t_eee();
        t_irq();
        do_reset(1'b0, 1'b0);
        t_mii10();
        do_reset(1'b1, 1'b1);
        t_rmii();
        report_and_stop();
    end
endmodule
